//--- src/exec_pkg.sv
// constants and types for the stack, port and machine-control executor
package exec_pkg;
   // register word offsets (byte addresses, low eight address bits)
   localparam logic [7:0] OFS_CMD    = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CTRL   = 8'h08;
   localparam logic [7:0] OFS_AF     = 8'h0C;
   localparam logic [7:0] OFS_BC     = 8'h10;
   localparam logic [7:0] OFS_DE     = 8'h14;
   localparam logic [7:0] OFS_HL     = 8'h18;
   localparam logic [7:0] OFS_SP     = 8'h1C;
   // control register bits
   localparam int CTRL_RESUME = 0;
   localparam int CTRL_ACK_TOP = 1;
   localparam int CTRL_TRAP = 2;
   // opcodes
   localparam logic [3:0] PUSH_LOW     = 4'h5;
   localparam logic [3:0] POP_LOW      = 4'h1;
   localparam logic [1:0] RP_FLAGS     = 2'h3;
   localparam logic [7:0] OP_XCHG_TOP  = 8'hE3;
   localparam logic [7:0] OP_LOAD_SP   = 8'hF9;
   localparam logic [7:0] OP_PORT_IN   = 8'hDB;
   localparam logic [7:0] OP_PORT_OUT  = 8'hD3;
   localparam logic [7:0] OP_IRQ_EN    = 8'hFB;
   localparam logic [7:0] OP_IRQ_DIS   = 8'hF3;
   localparam logic [7:0] OP_HALT      = 8'h76;
   localparam logic [7:0] OP_RD_MASK   = 8'h20;
   localparam logic [7:0] OP_SET_MASK  = 8'h30;
   // state totals per instruction
   localparam int ST_PUSH = 12;
   localparam int ST_POP = 10;
   localparam int ST_XCHG = 16;
   localparam int ST_LDSP = 6;
   localparam int ST_PORT = 10;
   localparam int ST_HALT = 5;
   localparam int ST_SHORT = 4;
   localparam int BUS_STATES = 3;
   // state period against the core clock
   localparam int CORE_PERIOD_NS = 5;
   localparam int STATE_PERIOD_NS = 10;
   localparam logic [1:0] STATE_CYCLES = 2'(STATE_PERIOD_NS / CORE_PERIOD_NS);
   // status word layout: sign 7, zero 6, aux carry 4, parity 2, carry 0
   localparam logic [7:0] FLAG_DEFINED = 8'hD5;
   // mask-set accumulator bits
   localparam int SET_MASK_EN = 3;
   localparam int SET_CLR_TOP = 4;
   localparam int SET_SER_EN = 6;
   localparam int SET_SER_BIT = 7;
   // reset values
   localparam logic [2:0] MASK_RST = 3'h7;
   localparam logic [15:0] SP_RST = 16'h0000;
   typedef enum {S_IDLE, S_LEAD, S_BUS, S_HALT} exec_state_t;
endpackage

//--- src/stack_io_exec.sv
// executor for the stack, port and machine-control instruction group
// Behaviour
// RULE1: pair push writes high at sp-1, low at sp-2, sp drops by 2
// RULE2: pair field code 3 selects accumulator and flags, never the stack pointer
// RULE3: flags push stores A at sp-1, flags at sp-2, sp-2, 12 states
// RULE4: flag word: sign 7, zero 6, aux carry 4, parity 2, carry 0
// RULE5: pair pop loads low from sp, high from sp+1, sp rises by 2
// RULE6: flags pop restores five flags from sp, A from sp+1, 10 states
// RULE7: stack-top exchange swaps L with (sp), H with (sp+1), 16 states
// RULE8: stack pointer load copies H and L into sp in 6 states
// RULE9: port input loads the byte a port drives into A, 10 states
// RULE10: port output drives A on the data bus, 10 states
// RULE11: enable op turns interrupts on only after the next instruction
// RULE12: disable op turns interrupts off at its end, 4 states
// RULE13: acknowledge responder must never supply enable or disable opcodes
// RULE14: halt stops with state kept, second address strobe, 5 states
// RULE15: mask read gives masks, enable flag, pending lines, serial input
// RULE16: first mask read after a trap reports the pre-trap enable flag
// RULE17: mask read bit 6 shows the top edge latch, set even when masked
// RULE18: mask set loads masks from bits 2..0 only when bit 3 is set
// RULE19: mask set with bit 4 set clears the top edge latch
// RULE20: top latch sets on rising edge; clears by reset, bit 4, unmasked ack
// RULE21: reset masks all three maskable restarts
// RULE22: mask set with bit 6 copies bit 7 to serial latch; reset clears
`timescale 1ns/1ps
module stack_io_exec (
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   // register bus
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // system bus
   output logic      [15:0] ADDR,
   output logic      [7:0]  DATA_OUT,
   output logic             DATA_OE_N,
   input  wire logic [7:0]  DATA_IN,
   output logic             ALE,
   output logic             RD_N,
   output logic             WR_N,
   output logic             IO_M,
   output logic             HALT_STS,
   // interrupt and serial pins
   input  wire logic        TOP_EDGE_IN,
   input  wire logic        MID_IRQ_IN,
   input  wire logic        LOW_IRQ_IN,
   input  wire logic        SERIAL_IN,
   output logic             SERIAL_OUT
);
   import exec_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic push_code(input logic [7:0] o);
      return o[7:6] == 2'h3 && o[3:0] == PUSH_LOW;
   endfunction

   function automatic logic pop_code(input logic [7:0] o);
      return o[7:6] == 2'h3 && o[3:0] == POP_LOW;
   endfunction

   function automatic logic [2:0] nbus_of(input logic [7:0] o);
      if (push_code(o) || pop_code(o))
         return 3'h2;
      else if (o == OP_XCHG_TOP)
         return 3'h4;
      else if (o == OP_PORT_IN || o == OP_PORT_OUT)
         return 3'h1;
      else
         return 3'h0;
   endfunction

   // idle states ahead of the bus cycles, so each op meets its total
   function automatic logic [4:0] lead_of(input logic [7:0] o);
      if (push_code(o))
         return 5'(ST_PUSH - 2 * BUS_STATES);           // see RULE3
      else if (pop_code(o))
         return 5'(ST_POP - 2 * BUS_STATES);            // see RULE6
      else if (o == OP_XCHG_TOP)
         return 5'(ST_XCHG - 4 * BUS_STATES);           // see RULE7
      else if (o == OP_LOAD_SP)
         return 5'(ST_LDSP);                            // see RULE8
      else if (o == OP_PORT_IN || o == OP_PORT_OUT)
         return 5'(ST_PORT - BUS_STATES);               // see RULE9
      else if (o == OP_HALT)
         return 5'(ST_HALT);                            // see RULE14
      else
         return 5'(ST_SHORT);                           // see RULE12
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   exec_state_t state;
   logic [1:0]  div_cnt;
   logic        tick;
   logic [11:0] s1, s2, s3, lvl;
   logic [7:0]  op, port, acc, flags, b, c, d, e, h, l, tmp0, tmp1;
   logic [15:0] sp;
   logic [4:0]  cnt;
   logic [1:0]  bph, bidx;
   logic        wr_cyc, wr_pend;
   logic [7:0]  wr_addr;
   logic        ien, en_pend, trap_flag, ien_saved, top_latch;
   logic [2:0]  mask;
   logic [31:0] rd_word;

   ////////////////////////////////////////////////////////////////////////////
   // state-rate enable

   always_ff @(posedge CORE_CLK)
   begin
      if (RST || div_cnt == STATE_CYCLES - 2'h1)
         div_cnt <= 2'h0;
      else
         div_cnt <= div_cnt + 2'h1;
      tick <= !RST && div_cnt == STATE_CYCLES - 2'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: 0 top edge, 1 mid, 2 low, 3 serial, 11..4 data bus

   wire logic [11:0] pins = {DATA_IN, SERIAL_IN, LOW_IRQ_IN, MID_IRQ_IN, TOP_EDGE_IN};

   for (genvar i = 0; i < 12; i++)
   begin : g_sync
      always_ff @(posedge CORE_CLK)
      begin
         s1[i] <= pins[i];
         s2[i] <= s1[i];
         s3[i] <= s2[i];
         if (RST)
            lvl[i] <= 1'b0;
         else if (s2[i] == s3[i])
            lvl[i] <= s3[i];
      end
   end

   // filter output ahead of its register, so a read byte is taken at the
   // edge that ends the strobe rather than one clock after the pins let go
   wire logic [11:0] next_lvl = (s3 & ~(s2 ^ s3)) | (lvl & (s2 ^ s3));
   wire logic        top_rise = next_lvl[0] && !lvl[0];
   wire logic [7:0]  din_byte = next_lvl[11:4];

   ////////////////////////////////////////////////////////////////////////////
   // operand selection

   wire logic       is_push = push_code(op);
   wire logic       is_pop  = pop_code(op);
   wire logic       is_xchg = op == OP_XCHG_TOP;
   wire logic       is_port = op == OP_PORT_IN || op == OP_PORT_OUT;
   wire logic       is_halt = op == OP_HALT;
   wire logic [1:0] rp      = op[5:4];
   wire logic [2:0] nbus    = nbus_of(op);
   wire logic [7:0] flag_word = flags & FLAG_DEFINED;   // see RULE4

   // field code 3 names accumulator and flags, so sp is never a pair here
   wire logic [7:0] pair_hi = rp == 2'h0 ? b : rp == 2'h1 ? d : rp == 2'h2 ? h : acc;
   wire logic [7:0] pair_lo = rp == 2'h0 ? c : rp == 2'h1 ? e : rp == 2'h2 ? l
                            : flag_word;                // see RULE2

   wire logic [15:0] sp_m1 = sp - 16'h0001;
   wire logic [15:0] sp_m2 = sp - 16'h0002;
   wire logic [15:0] sp_p1 = sp + 16'h0001;
   wire logic [15:0] sp_p2 = sp + 16'h0002;

   // index of the bus cycle about to be launched
   wire logic [1:0] aidx = state == S_BUS ? bidx + 2'h1 : 2'h0;

   wire logic [15:0] cyc_addr = is_push ? (aidx == 2'h0 ? sp_m1 : sp_m2)  // see RULE1
                              : is_port ? {port, port}
                              : aidx[0] ? sp_p1 : sp;                    // see RULE5
   wire logic        cyc_write = is_push || (is_xchg && aidx[1]) || op == OP_PORT_OUT;
   wire logic [7:0]  cyc_wbyte = is_push ? (aidx == 2'h0 ? pair_hi : pair_lo)
                               : is_xchg ? (aidx[0] ? h : l)             // see RULE7
                               : acc;                                    // see RULE10

   wire logic last_cyc = {1'b0, bidx} == nbus - 3'h1;
   wire logic lead_end = tick && state == S_LEAD && cnt == 5'h0;
   wire logic bus_end  = tick && state == S_BUS && bph == 2'h2;
   wire logic launch   = (lead_end && nbus != 3'h0) || (bus_end && !last_cyc);
   wire logic finish   = (lead_end && nbus == 3'h0) || (bus_end && last_cyc);

   wire logic ien_rep = trap_flag ? ien_saved : ien;     // see RULE16
   wire logic [7:0] msk_byte = {lvl[3], top_latch, lvl[1], lvl[2], ien_rep, mask};

   ////////////////////////////////////////////////////////////////////////////
   // register bus slave

   wire logic addr_ph = HSEL && HTRANS[1] && HREADY;
   wire logic reg_wr  = wr_pend && state == S_IDLE;
   wire logic ctrl_wr = wr_pend && wr_addr == OFS_CTRL;
   wire logic start   = reg_wr && wr_addr == OFS_CMD;
   wire logic resume  = ctrl_wr && HWDATA[CTRL_RESUME];

   always_comb
   begin
      if (HADDR[7:0] == OFS_CMD)
         rd_word = {16'h0000, port, op};
      else if (HADDR[7:0] == OFS_STATUS)
         rd_word = {16'h0000, top_latch, mask, SERIAL_OUT, trap_flag, en_pend, ien,
                    6'h00, state == S_HALT, state != S_IDLE};
      else if (HADDR[7:0] == OFS_AF)
         rd_word = {16'h0000, acc, flag_word};
      else if (HADDR[7:0] == OFS_BC)
         rd_word = {16'h0000, b, c};
      else if (HADDR[7:0] == OFS_DE)
         rd_word = {16'h0000, d, e};
      else if (HADDR[7:0] == OFS_HL)
         rd_word = {16'h0000, h, l};
      else if (HADDR[7:0] == OFS_SP)
         rd_word = {16'h0000, sp};
      else
         rd_word = 32'h0000_0000;
   end

   // zero wait states: read data is taken at the address phase
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         HRDATA    <= 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
      else
      begin
         wr_pend <= addr_ph && HWRITE;
         if (addr_ph)
            wr_addr <= HADDR[7:0];
         if (addr_ph && !HWRITE)
            HRDATA <= rd_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer and system bus pins

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         state     <= S_IDLE;
         op        <= 8'h00;
         port      <= 8'h00;
         cnt       <= 5'h00;
         bph       <= 2'h0;
         bidx      <= 2'h0;
         wr_cyc    <= 1'b0;
         ADDR      <= 16'h0000;
         DATA_OUT  <= 8'h00;
         DATA_OE_N <= 1'b1;
         ALE       <= 1'b0;
         RD_N      <= 1'b1;
         WR_N      <= 1'b1;
         IO_M      <= 1'b0;
         HALT_STS  <= 1'b0;
      end
      else
      begin
         case (state)
            S_IDLE:
               if (start)
               begin
                  op    <= HWDATA[7:0];
                  port  <= HWDATA[15:8];
                  cnt   <= lead_of(HWDATA[7:0]) - 5'h01;
                  state <= S_LEAD;
               end
            S_LEAD:
               if (tick)
               begin
                  // halt puts out a second strobe carrying halt status
                  ALE <= is_halt && cnt == 5'h02;              // see RULE14
                  if (is_halt && cnt == 5'h02)
                     HALT_STS <= 1'b1;
                  if (cnt != 5'h00)
                     cnt <= cnt - 5'h01;
                  else if (nbus == 3'h0)
                     state <= is_halt ? S_HALT : S_IDLE;
                  else
                     state <= S_BUS;
               end
            S_BUS:
               if (tick)
               begin
                  if (bph == 2'h0)
                  begin
                     ALE  <= 1'b0;
                     RD_N <= wr_cyc;
                     WR_N <= !wr_cyc;
                  end
                  if (bph == 2'h2)
                  begin
                     RD_N      <= 1'b1;
                     WR_N      <= 1'b1;
                     DATA_OE_N <= 1'b1;
                     IO_M      <= 1'b0;
                     if (last_cyc)
                        state <= S_IDLE;
                  end
                  bph <= bph == 2'h2 ? 2'h0 : bph + 2'h1;
               end
            S_HALT:
               // registers stay as they are until software resumes
               if (resume)
               begin
                  state    <= S_IDLE;
                  HALT_STS <= 1'b0;
               end
            default:
               state <= S_IDLE;
         endcase
         if (launch)
         begin
            ADDR      <= cyc_addr;
            ALE       <= 1'b1;
            IO_M      <= is_port;
            DATA_OUT  <= cyc_wbyte;
            DATA_OE_N <= !cyc_write;
            wr_cyc    <= cyc_write;
            bidx      <= aidx;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // working registers

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         {acc, flags, b, c, d, e, h, l, tmp0, tmp1} <= 80'h0;
         sp <= SP_RST;
      end
      else if (reg_wr)
      begin
         if (wr_addr == OFS_AF)
            {acc, flags} <= {HWDATA[15:8], HWDATA[7:0] & FLAG_DEFINED};
         else if (wr_addr == OFS_BC)
            {b, c} <= HWDATA[15:0];
         else if (wr_addr == OFS_DE)
            {d, e} <= HWDATA[15:0];
         else if (wr_addr == OFS_HL)
            {h, l} <= HWDATA[15:0];
         else if (wr_addr == OFS_SP)
            sp <= HWDATA[15:0];
      end
      else
      begin
         if (bus_end && !wr_cyc)
         begin
            if (bidx[0])
               tmp1 <= din_byte;
            else
               tmp0 <= din_byte;
         end
         if (finish)
         begin
            if (is_push)
               sp <= sp_m2;                                  // see RULE1
            else if (is_pop)
            begin
               sp <= sp_p2;                                  // see RULE5
               case (rp)
                  2'h0: {b, c} <= {din_byte, tmp0};
                  2'h1: {d, e} <= {din_byte, tmp0};
                  2'h2: {h, l} <= {din_byte, tmp0};
                  default: {acc, flags} <= {din_byte, tmp0 & FLAG_DEFINED};  // see RULE6
               endcase
            end
            else if (is_xchg)
               {h, l} <= {tmp1, tmp0};                       // see RULE7
            else if (op == OP_LOAD_SP)
               sp <= {h, l};                                 // see RULE8
            else if (op == OP_PORT_IN)
               acc <= din_byte;                              // see RULE9
            else if (op == OP_RD_MASK)
               acc <= msk_byte;                              // see RULE15
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt control state

   wire logic smk_fin = finish && op == OP_SET_MASK;
   // acknowledge only reaches the latch once its restart is unmasked
   wire logic top_clr = (smk_fin && acc[SET_CLR_TOP])                     // see RULE19
                      || (ctrl_wr && HWDATA[CTRL_ACK_TOP] && !mask[2]);

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         ien        <= 1'b0;
         en_pend    <= 1'b0;
         trap_flag  <= 1'b0;
         ien_saved  <= 1'b0;
         mask       <= MASK_RST;                             // see RULE21
         top_latch  <= 1'b0;
         SERIAL_OUT <= 1'b0;                                 // see RULE22
      end
      else
      begin
         if (finish)
         begin
            if (op == OP_IRQ_EN)
               en_pend <= 1'b1;                              // see RULE11
            else if (op == OP_IRQ_DIS)
            begin
               ien     <= 1'b0;                              // see RULE12
               en_pend <= 1'b0;
            end
            else if (en_pend)
            begin
               ien     <= 1'b1;                              // see RULE11
               en_pend <= 1'b0;
            end
            if (op == OP_RD_MASK)
               trap_flag <= 1'b0;                            // see RULE16
            if (smk_fin && acc[SET_MASK_EN])
               mask <= acc[2:0];                             // see RULE18
            if (smk_fin && acc[SET_SER_EN])
               SERIAL_OUT <= acc[SET_SER_BIT];               // see RULE22
         end
         if (ctrl_wr && HWDATA[CTRL_TRAP])
         begin
            ien_saved <= ien;                                // see RULE16
            trap_flag <= 1'b1;
            ien       <= 1'b0;
            en_pend   <= 1'b0;
         end
         // a rising edge wins over a clear in the same cycle
         if (top_rise)
            top_latch <= 1'b1;                               // see RULE20
         else if (top_clr)
            top_latch <= 1'b0;                               // see RULE20
      end
   end

endmodule // stack_io_exec

//--- bench/exec_sva.sv
// pin-level assertions for the stack, port and machine-control executor
`timescale 1ns/1ps
module exec_sva (
   // clock, reset and pins watched
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic [15:0] ADDR,
   input wire logic        DATA_OE_N,
   input wire logic        ALE,
   input wire logic        RD_N,
   input wire logic        WR_N,
   input wire logic        IO_M,
   input wire logic        HALT_STS,
   input wire logic        SERIAL_OUT
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   ////////////////////////////////////////////////////////////////////////////////
   // a strobe lasts two states of two clocks each
   sequence s_read_strobe;
      !RD_N [*4] ##1 RD_N;
   endsequence
   sequence s_write_strobe;
      !WR_N [*4] ##1 WR_N;
   endsequence
   a_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus answer not zero-wait okay");
   a_read_len: assert property ($fell(RD_N) |-> s_read_strobe)
      else $error("read strobe length wrong");
   a_write_len: assert property ($fell(WR_N) |-> s_write_strobe)
      else $error("write strobe length wrong");
   a_write_drive: assert property (!WR_N |-> !DATA_OE_N)
      else $error("data pins not driven during write");
   a_addr_stable: assert property (!(RD_N && WR_N) |-> $stable(ADDR) && $stable(IO_M))
      else $error("address moved under a strobe");
   a_ale_pulse: assert property ($rose(ALE) |=> ALE ##1 !ALE)
      else $error("address strobe not one state");
   a_ale_follow: assert property ($rose(ALE) |-> ##2 (!RD_N || !WR_N || HALT_STS))
      else $error("address strobe without a cycle");
   a_halt_strobe: assert property ($rose(HALT_STS) |-> ALE)
      else $error("halt status without second strobe");
   a_serial_reset: assert property ($fell(RST) |-> !SERIAL_OUT && !HALT_STS)
      else $error("serial latch not cleared by reset");
endmodule // exec_sva

bind stack_io_exec exec_sva exec_sva_inst (
   .CORE_CLK(CORE_CLK), .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .ADDR(ADDR), .DATA_OE_N(DATA_OE_N), .ALE(ALE), .RD_N(RD_N), .WR_N(WR_N),
   .IO_M(IO_M), .HALT_STS(HALT_STS), .SERIAL_OUT(SERIAL_OUT));

//--- bench/sysbus_model.sv
// memory and port model on the system bus
`timescale 1ns/1ps
module sysbus_model (
   // system bus
   input wire logic        clk,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic        io_m,
   output logic     [7:0]  rdata
);
   logic [7:0]       mem [logic [16:0]];
   wire logic [16:0] key = {io_m, addr};
   initial rdata = 8'h00;
   // a port answers half a clock after the strobe falls, as real pins would
   always @(negedge clk)
   begin
      // only plain data bytes are answered, never an acknowledge opcode
      if (!rd_n)
         rdata <= mem[key];
      else
         rdata <= ~rdata; // released pins invert each clock, so the stale byte shows every other clock
      if (!wr_n)
         mem[key] = wdata;
   end
endmodule // sysbus_model

//--- bench/stack_io_exec_tb.sv
// self-checking bench for the stack, port and machine-control executor
`timescale 1ns/1ps
module stack_io_exec_tb;
   import exec_pkg::*;
   logic        CORE_CLK = 1'b0;
   logic        RST = 1'b1;
   logic        HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [1:0]  HTRANS = 2'h0;
   logic        HWRITE = 1'b0;
   logic [31:0] HWDATA = 32'h0;
   logic        TOP_EDGE_IN = 1'b0;
   logic [31:0] HRDATA, d;
   logic [15:0] ADDR;
   logic [7:0]  DATA_OUT, DATA_IN;
   logic        HREADYOUT, HRESP, DATA_OE_N, ALE, RD_N, WR_N, IO_M, HALT_STS, SERIAL_OUT;
   int          bad_count = 0;
   int          checked = 0;
   always #2.5 CORE_CLK = ~CORE_CLK;
   stack_io_exec stack_io_exec_inst (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
      .ADDR(ADDR), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .DATA_IN(DATA_IN),
      .ALE(ALE), .RD_N(RD_N), .WR_N(WR_N), .IO_M(IO_M), .HALT_STS(HALT_STS),
      .TOP_EDGE_IN(TOP_EDGE_IN), .MID_IRQ_IN(1'b0), .LOW_IRQ_IN(1'b1),
      .SERIAL_IN(1'b1), .SERIAL_OUT(SERIAL_OUT));
   sysbus_model sysbus_model_inst (.clk(CORE_CLK), .addr(ADDR), .wdata(DATA_OUT),
      .rd_n(RD_N), .wr_n(WR_N), .io_m(IO_M), .rdata(DATA_IN));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge CORE_CLK);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= w;
      @(posedge CORE_CLK);
      while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      @(posedge CORE_CLK);
      while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
      d = HRDATA;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
      xfer(1'b0, a, 32'h0);
      chk(n, e, d);
   endtask
   task automatic mchk(input logic [16:0] k, input logic [7:0] e);
      chk("bus byte", {24'h0, e}, {24'h0, sysbus_model_inst.mem[k]});
   endtask
   task automatic cmd(input logic [7:0] op, input logic [7:0] p);
      int n;
      xfer(1'b1, OFS_CMD, {16'h0, p, op});
      n = 0;
      do
      begin
         xfer(1'b0, OFS_STATUS, 32'h0);
         n++;
      end
      while (d[0] !== 1'b0 && d[1] !== 1'b1 && n < 200);
      chk("busy", 32'h0, {31'h0, d[0] & ~d[1]});
   endtask
   task automatic setm(input logic [7:0] a);
      xfer(1'b1, OFS_AF, {16'h0, a, 8'h00});
      cmd(OP_SET_MASK, 8'h00);
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (40000) @(posedge CORE_CLK);
      bad_count++;
      close_out();
   end
   initial
   begin
      sysbus_model_inst.mem[17'h00100] = 8'h11;
      sysbus_model_inst.mem[17'h00101] = 8'h22;
      sysbus_model_inst.mem[17'h14040] = 8'h5A;
      repeat (6) @(posedge CORE_CLK);
      RST <= 1'b0;
      rchk(OFS_STATUS, 32'h7000, "status");
      xfer(1'b1, OFS_BC, 32'h1234);
      xfer(1'b1, OFS_SP, 32'h0100);
      xfer(1'b1, OFS_AF, 32'hABFF);
      cmd(8'hC5, 8'h00);
      mchk(17'h000FF, 8'h12);
      mchk(17'h000FE, 8'h34);
      cmd(8'hF5, 8'h00);
      mchk(17'h000FD, 8'hAB);
      mchk(17'h000FC, 8'hD5);
      rchk(OFS_SP, 32'h00FC, "sp");
      cmd(8'hD1, 8'h00);
      rchk(OFS_DE, 32'hABD5, "de");
      cmd(8'hF1, 8'h00);
      rchk(OFS_AF, 32'h1214, "af");
      rchk(OFS_SP, 32'h0100, "sp");
      xfer(1'b1, OFS_HL, 32'h5678);
      cmd(OP_XCHG_TOP, 8'h00);
      rchk(OFS_HL, 32'h2211, "hl");
      mchk(17'h00100, 8'h78);
      mchk(17'h00101, 8'h56);
      cmd(OP_LOAD_SP, 8'h00);
      rchk(OFS_SP, 32'h2211, "sp");
      $display("stack tests done");
      cmd(OP_PORT_IN, 8'h40);
      rchk(OFS_AF, 32'h5A14, "af");
      cmd(OP_PORT_OUT, 8'h41);
      mchk(17'h14141, 8'h5A);
      cmd(OP_IRQ_EN, 8'h00);
      rchk(OFS_STATUS, 32'h7200, "status");
      cmd(8'h00, 8'h00);
      rchk(OFS_STATUS, 32'h7100, "status");
      cmd(OP_IRQ_DIS, 8'h00);
      rchk(OFS_STATUS, 32'h7000, "status");
      $display("port and enable tests done");
      setm(8'h0C);
      setm(8'h05);
      rchk(OFS_STATUS, 32'h4000, "status");
      TOP_EDGE_IN <= 1'b1;
      repeat (8) @(posedge CORE_CLK);
      rchk(OFS_STATUS, 32'hC000, "status");
      cmd(OP_RD_MASK, 8'h00);
      rchk(OFS_AF, 32'hD400, "af");
      xfer(1'b1, OFS_CTRL, 32'h2);
      rchk(OFS_STATUS, 32'hC000, "status");
      TOP_EDGE_IN <= 1'b0;
      setm(8'h10);
      rchk(OFS_STATUS, 32'h4000, "status");
      setm(8'h08);
      TOP_EDGE_IN <= 1'b1;
      repeat (8) @(posedge CORE_CLK);
      rchk(OFS_STATUS, 32'h8000, "status");
      xfer(1'b1, OFS_CTRL, 32'h2);
      rchk(OFS_STATUS, 32'h0000, "status");
      setm(8'hC0);
      setm(8'h00);
      chk("serial out", 32'h1, {31'h0, SERIAL_OUT});
      rchk(OFS_STATUS, 32'h0800, "status");
      $display("mask tests done");
      cmd(OP_IRQ_EN, 8'h00);
      cmd(8'h00, 8'h00);
      xfer(1'b1, OFS_CTRL, 32'h4);
      cmd(OP_RD_MASK, 8'h00);
      rchk(OFS_AF, 32'h9800, "af");
      cmd(OP_RD_MASK, 8'h00);
      rchk(OFS_AF, 32'h9000, "af");
      cmd(OP_HALT, 8'h00);
      chk("halt status", 32'h1, {31'h0, HALT_STS});
      xfer(1'b1, OFS_AF, 32'h1111);
      rchk(OFS_AF, 32'h9000, "af");
      xfer(1'b1, OFS_CTRL, 32'h1);
      repeat (4) @(posedge CORE_CLK);
      chk("halt status", 32'h0, {31'h0, HALT_STS});
      $display("trap and halt tests done");
      close_out();
   end
endmodule // stack_io_exec_tb
